// [verilog/dmr_pkg.sv]
// Constants and carrier types for the DRAM mode-register and burst-order block.
// Assumes one 250 MHz clock and an APB register port.
package dmr_pkg;
	localparam int ADDR_W = 14;
	localparam int COL_W = 12;
	// Register select codes on the two bank-address bits.
	localparam logic [1:0] SEL_BASE = 2'h0;
	localparam logic [1:0] SEL_EXT = 2'h1;
	// Base register fields.
	localparam int BL_LSB = 0;
	localparam int BT_BIT = 3;
	localparam int LAT_LSB = 4;
	localparam int OPM_LSB = 7;
	localparam int DLLRST_BIT = 8;
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] LAT_CODE_2 = 3'h2;
	localparam logic [2:0] LAT_CODE_25 = 3'h6;
	// Extended register fields: bit 0 disables the DLL, bit 1 selects reduced drive.
	localparam int EXT_DLLDIS_BIT = 0;
	localparam int EXT_DRIVE_BIT = 1;
	localparam logic [ADDR_W-1:0] BASE_RST = 14'h0;
	localparam logic [ADDR_W-1:0] EXT_RST = 14'h0;
	// Latency in half clocks: 2 clocks and 2.5 clocks.
	localparam logic [2:0] HALF_LAT_2 = 3'h4;
	localparam logic [2:0] HALF_LAT_25 = 3'h5;
	// DLL lock wait, in DRAM clocks.
	localparam int DLL_WAIT_CYC = 200;
	// APB map.
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_BASE = 8'h04;
	localparam logic [7:0] OFS_EXT = 8'h08;
	localparam logic [7:0] OFS_READ = 8'h0c;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_ORDER = 8'h14;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} dmr_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dmr_apb_rsp_t;
endpackage : dmr_pkg

// [verilog/dmr_mode_ctl.sv]
// Mode registers, burst ordering and read-latency timing of a DDR memory device.
// Assumes a synchronous APB master; mode-register loads arrive as APB writes to the command word, read commands as writes to OFS_READ.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dmr_mode_ctl #(
	parameter bit WIDE_COL = 1'b0,
	parameter int DLL_WAIT = dmr_pkg::DLL_WAIT_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire dmr_pkg::dmr_apb_req_t apb_req,
	output dmr_pkg::dmr_apb_rsp_t apb_rsp,
	input wire logic self_refresh_exit,
	output logic [dmr_pkg::COL_W-1:0] burst_col,
	output logic burst_valid,
	output logic read_data_valid,
	output logic read_half_phase,
	output logic dll_enabled,
	output logic drive_reduced
);
	import dmr_pkg::*;

	// The lock counter is 16 bits wide and the column logic is built for 12 column bits.
	if (DLL_WAIT < 1 || DLL_WAIT > 65535) begin : g_bad_wait
		$error("DLL_WAIT out of range");
	end
	if (COL_W != 12) begin : g_bad_col
		$error("COL_W must be 12");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BURST = 3'b010,
		ST_DONE = 3'b100
	} dmr_state_t;

	////////////////////////////////////////////////////////////////////////////
	// APB decode. Every access completes in its first access cycle.
	wire logic acc = apb_req.psel && apb_req.penable;
	wire logic wr = acc && apb_req.pwrite;
	wire logic hit_cmd = apb_req.paddr == OFS_CMD;
	wire logic hit_read = apb_req.paddr == OFS_READ;
	wire logic hit_base = apb_req.paddr == OFS_BASE;
	wire logic hit_ext = apb_req.paddr == OFS_EXT;
	wire logic hit_stat = apb_req.paddr == OFS_STAT;
	wire logic hit_order = apb_req.paddr == OFS_ORDER;
	wire logic mapped = hit_cmd || hit_read || hit_base || hit_ext || hit_stat || hit_order;
	// Command word: bits 13..0 op-code, bits 15..14 select (bank address).
	wire logic [1:0] cmd_sel = apb_req.pwdata[15:14];
	wire logic [ADDR_W-1:0] cmd_op = apb_req.pwdata[ADDR_W-1:0];
	wire logic load_base = wr && hit_cmd && cmd_sel == SEL_BASE;
	wire logic load_ext = wr && hit_cmd && cmd_sel == SEL_EXT;

	logic [ADDR_W-1:0] base_ff;
	logic [ADDR_W-1:0] ext_ff;
	logic dll_rst_ff;
	logic [15:0] dll_cnt_ff;
	logic dll_en_ff;
	logic [31:0] prdata_ff;

	// A8 is kept as a one-cycle reset request and never stored.
	wire logic [ADDR_W-1:0] nxt_base = load_base ? (cmd_op & ~(14'h1 << DLLRST_BIT)) : base_ff;
	wire logic dll_reset_req = load_base && cmd_op[ADDR_W-1:OPM_LSB] == 7'h02;
	wire logic dll_on_cmd = load_ext && !cmd_op[EXT_DLLDIS_BIT];
	wire logic nxt_dll_en = self_refresh_exit ? 1'b1
		: (load_ext ? !cmd_op[EXT_DLLDIS_BIT] : dll_en_ff);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			base_ff <= BASE_RST;
			ext_ff <= EXT_RST;
			// The DLL leaves reset enabled, as power-up initialisation requires.
			dll_en_ff <= 1'b1;
			dll_rst_ff <= 1'b0;
		end else begin
			base_ff <= nxt_base;
			if (load_ext) begin
				ext_ff <= cmd_op;
			end
			dll_en_ff <= nxt_dll_en;
			dll_rst_ff <= dll_reset_req;
		end
	end

	// Lock counter restarts on every DLL enable or reset except the enable at sys_rst, which clears it to zero; status shows when it has run out.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dll_cnt_ff <= 16'h0;
		end else if (dll_reset_req || dll_on_cmd || self_refresh_exit) begin
			dll_cnt_ff <= DLL_WAIT[15:0];
		end else if (dll_cnt_ff != 16'h0) begin
			dll_cnt_ff <= dll_cnt_ff - 16'h1;
		end
	end

	assign dll_enabled = dll_en_ff;
	assign drive_reduced = ext_ff[EXT_DRIVE_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Field decode.
	wire logic [2:0] bl_code = base_ff[BL_LSB+2:BL_LSB];
	wire logic seq_order = !base_ff[BT_BIT];
	wire logic [2:0] lat_code = base_ff[LAT_LSB+2:LAT_LSB];
	wire logic [2:0] step_mask = (bl_code == BL_CODE_8) ? 3'h7
		: (bl_code == BL_CODE_4) ? 3'h3 : 3'h1;
	wire logic [2:0] half_lat = (lat_code == LAT_CODE_25) ? HALF_LAT_25 : HALF_LAT_2;
	// Column bits above A9 are zero unless the wide organisation also uses A11.
	wire logic [COL_W-1:0] col_mask = WIDE_COL ? 12'hbff : 12'h3ff;

	////////////////////////////////////////////////////////////////////////////
	// Read command and burst address walk.
	dmr_state_t state_ff;
	dmr_state_t nxt_state;
	logic [COL_W-1:0] start_ff;
	logic [2:0] step_ff;
	logic [2:0] lat_cnt_ff;
	logic [COL_W-1:0] col_ff;
	logic burst_ff;

	wire logic read_cmd = wr && hit_read && state_ff == ST_IDLE;
	wire logic [2:0] low_start = start_ff[2:0] & step_mask;
	wire logic [2:0] seq_low = (low_start + step_ff) & step_mask;
	wire logic [2:0] il_low = (low_start ^ step_ff) & step_mask;
	wire logic [2:0] pick_low = seq_order ? seq_low : il_low;
	// Block bits come from the start address and never change, so the burst wraps in place.
	wire logic [COL_W-1:0] nxt_col = {start_ff[COL_W-1:3], 3'h0}
		| {9'h0, start_ff[2:0] & ~step_mask} | {9'h0, pick_low};
	// Two half clocks pass per edge. Once fewer than four halves remain the next edge launches
	// data; a leftover half clock is shown on read_half_phase rather than costing an edge.
	localparam logic [2:0] HALF_PER_CLK = 3'h2;
	localparam logic [2:0] LAST_HALVES = 3'h3;
	wire logic lat_done = lat_cnt_ff <= LAST_HALVES;
	wire logic last_step = step_ff == step_mask;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (read_cmd) begin
					nxt_state = ST_BURST;
				end
			end
			ST_BURST: begin
				if (lat_done && last_step) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Latency counts in half clocks; two half clocks are spent per clock edge.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= ST_IDLE;
			start_ff <= '0;
			step_ff <= 3'h0;
			lat_cnt_ff <= 3'h0;
			col_ff <= '0;
			burst_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			burst_ff <= 1'b0;
			if (read_cmd) begin
				start_ff <= apb_req.pwdata[COL_W-1:0] & col_mask;
				step_ff <= 3'h0;
				lat_cnt_ff <= half_lat;
			end else if (state_ff == ST_BURST) begin
				if (!lat_done) begin
					lat_cnt_ff <= lat_cnt_ff - HALF_PER_CLK;
				end else begin
					col_ff <= nxt_col;
					burst_ff <= 1'b1;
					step_ff <= step_ff + 3'h1;
				end
			end
		end
	end

	assign burst_col = col_ff;
	assign burst_valid = burst_ff;
	assign read_data_valid = burst_ff;
	// High when the first data lands half a clock after the edge (latency 2.5).
	assign read_half_phase = burst_ff && half_lat[0];

	////////////////////////////////////////////////////////////////////////////
	// Read data and answer.
	wire logic [31:0] stat_word = {14'h0, dll_cnt_ff == 16'h0, dll_rst_ff,
		dll_en_ff, state_ff == ST_IDLE, dll_cnt_ff[11:0], 2'h0};
	wire logic [31:0] rd_mux = hit_base ? {18'h0, base_ff}
		: hit_ext ? {18'h0, ext_ff}
		: hit_stat ? stat_word
		: hit_order ? {20'h0, col_ff} : 32'h0;

	// Read data is captured in the setup cycle so that it already stands when pready is
	// sampled; a register that moves between setup and access shows its setup value.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prdata_ff <= 32'h0;
		end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
			prdata_ff <= rd_mux;
		end
	end

	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = acc && !mapped;
	assign apb_rsp.prdata = prdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the registers, the DLL controls and the burst walk.
	a_ext_holds: assert property (@(posedge clk) disable iff (sys_rst)
		load_base |=> $stable(ext_ff))
		else $error("extended register changed on a base load");
	a_base_holds: assert property (@(posedge clk) disable iff (sys_rst)
		load_ext |=> $stable(base_ff))
		else $error("base register changed on an extended load");
	a_a8_clears: assert property (@(posedge clk) disable iff (sys_rst)
		!base_ff[DLLRST_BIT])
		else $error("DLL reset bit was stored");
	a_dll_rst_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		dll_reset_req |=> dll_rst_ff ##1 !dll_rst_ff || dll_reset_req)
		else $error("DLL reset pulse wrong");
	a_sr_exit_dll: assert property (@(posedge clk) disable iff (sys_rst)
		self_refresh_exit |=> dll_en_ff)
		else $error("DLL not enabled after self refresh exit");
	a_in_block: assert property (@(posedge clk) disable iff (sys_rst)
		burst_ff |-> (col_ff & ~{9'h0, step_mask}) == (start_ff & ~{9'h0, step_mask}))
		else $error("burst left its block");
	a_first_col: assert property (@(posedge clk) disable iff (sys_rst)
		burst_ff && $past(step_ff) == 3'h0 |-> col_ff == start_ff)
		else $error("burst did not start at start column");
	a_lat_two: assert property (@(posedge clk) disable iff (sys_rst)
		read_cmd && lat_code == LAT_CODE_2 |=> !burst_ff ##1 !burst_ff ##1 burst_ff)
		else $error("latency 2 first data off its edge");
	a_drive_bit: assert property (@(posedge clk) disable iff (sys_rst)
		load_ext |=> drive_reduced == $past(cmd_op[EXT_DRIVE_BIT]))
		else $error("drive strength not taken");
	a_lat_half: assert property (@(posedge clk) disable iff (sys_rst)
		read_cmd && lat_code == LAT_CODE_25 |=> !burst_ff ##1 !burst_ff
		##1 (burst_ff && read_half_phase))
		else $error("latency 2.5 first data off its edge");
	a_half_only: assert property (@(posedge clk) disable iff (sys_rst)
		read_half_phase |-> lat_code == LAT_CODE_25)
		else $error("half clock flagged without latency 2.5");
	a_seq_next: assert property (@(posedge clk) disable iff (sys_rst)
		burst_ff && $past(burst_ff) && seq_order
		|-> (col_ff[2:0] & step_mask) == (($past(col_ff[2:0]) + 3'h1) & step_mask))
		else $error("sequential burst skipped a column");
	a_il_next: assert property (@(posedge clk) disable iff (sys_rst)
		burst_ff && !seq_order
		|-> ((col_ff[2:0] ^ start_ff[2:0]) & step_mask) == ($past(step_ff) & step_mask))
		else $error("interleaved burst out of order");
	a_burst_stop: assert property (@(posedge clk) disable iff (sys_rst)
		burst_ff && $past(step_ff) == step_mask |=> !burst_ff)
		else $error("burst ran past its length");
	a_col_range: assert property (@(posedge clk) disable iff (sys_rst)
		burst_ff |-> (col_ff & ~col_mask) == '0)
		else $error("burst column outside the column bits");
	a_block_bits: assert property (@(posedge clk) disable iff (sys_rst)
		burst_ff |-> col_ff[COL_W-1:3] == start_ff[COL_W-1:3])
		else $error("burst moved its block address");
	a_dll_wait: assert property (@(posedge clk) disable iff (sys_rst)
		dll_reset_req || dll_on_cmd || self_refresh_exit |=> dll_cnt_ff == DLL_WAIT[15:0])
		else $error("DLL lock wait not restarted");
	a_ext_dll_bit: assert property (@(posedge clk) disable iff (sys_rst)
		load_ext && !self_refresh_exit |=> dll_en_ff == !$past(cmd_op[EXT_DLLDIS_BIT]))
		else $error("DLL enable not taken from extended register");
	a_reserved_sel: assert property (@(posedge clk) disable iff (sys_rst)
		wr && hit_cmd && cmd_sel[1] |=> $stable(base_ff) && $stable(ext_ff))
		else $error("reserved select changed a mode register");
	a_base_load: assert property (@(posedge clk) disable iff (sys_rst)
		load_base |=> base_ff[OPM_LSB-1:0] == $past(cmd_op[OPM_LSB-1:0]))
		else $error("base burst and latency fields not stored");
endmodule : dmr_mode_ctl
`default_nettype wire

// [testbench/dmr_host.sv]
// Controller-side model: issues APB transfers and mode-register loads.
// Assumes the block answers with pready; one idle cycle follows each transfer.
`timescale 1ns/1ps
`default_nettype none
module dmr_host (
	input wire logic clk,
	input wire dmr_pkg::dmr_apb_rsp_t rsp,
	output dmr_pkg::dmr_apb_req_t req
);
	import dmr_pkg::*;
	initial req = '0;
	// The trailing idle cycle is the wait that must follow every load.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		@(posedge clk);
	endtask : xfer
	task automatic load(input logic [1:0] sel, input logic [13:0] op);
		logic [31:0] rd;
		logic err;
		xfer(1'b1, OFS_CMD, {16'h0, sel, op}, rd, err);
	endtask : load
endmodule : dmr_host
`default_nettype wire

// [testbench/ddr_mode_register_burst_order_tb.sv]
// Self-checking bench for the mode-register and burst-order block.
// Assumes the host model in dmr_host.sv drives the APB port.
`timescale 1ns/1ps
`default_nettype none
module ddr_mode_register_burst_order_tb;
	import dmr_pkg::*;
	logic clk, sys_rst, srx, bv, rdv, half, dll, drv, err;
	logic [11:0] col;
	logic [31:0] rd;
	dmr_apb_req_t req;
	dmr_apb_rsp_t rsp;
	int errors, checks, cyc;
	dmr_mode_ctl #(.WIDE_COL(1'b0), .DLL_WAIT(4)) dmr_mode_ctl_i (.clk(clk), .sys_rst(sys_rst),
		.apb_req(req), .apb_rsp(rsp), .self_refresh_exit(srx), .burst_col(col),
		.burst_valid(bv), .read_data_valid(rdv), .read_half_phase(half),
		.dll_enabled(dll), .drive_reduced(drv));
	dmr_host dmr_host_i (.clk(clk), .rsp(rsp), .req(req));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	// Block base from the high bits, offset wraps inside the block; A10 and A11 drop.
	function automatic logic [11:0] exp_col(logic [11:0] s, int bl, logic il, int i);
		logic [11:0] m;
		m = 12'(bl - 1);
		return ((s & ~m) | ((il ? (s ^ 12'(i)) : (s + 12'(i))) & m)) & 12'h3ff;
	endfunction : exp_col
	task automatic rdreg(logic [7:0] a);
		dmr_host_i.xfer(1'b0, a, 32'h0, rd, err);
	endtask : rdreg
	task automatic burst(logic [2:0] blc, logic il, logic [2:0] lat, logic [11:0] s);
		int bl;
		logic v;
		bl = 1 << blc;
		dmr_host_i.load(SEL_BASE, {7'h0, lat, il, blc});
		rdreg(OFS_BASE);
		chk("base", rd, {25'h0, lat, il, blc});
		dmr_host_i.xfer(1'b1, OFS_READ, {20'h0, s}, rd, err);
		for (int k = 1; k <= bl + 2; k++) begin
			if (k > 1) @(posedge clk);
			#1;
			v = (k >= 2) && (k < bl + 2);
			chk("valid", bv, v);
			chk("rdvalid", rdv, v);
			chk("half", half, v && lat == LAT_CODE_25);
			if (v) chk("col", col, exp_col(s, bl, il, k - 2));
		end
		@(posedge clk);
		rdreg(OFS_ORDER);
		chk("order", rd, {20'h0, exp_col(s, bl, il, bl - 1)});
	endtask : burst
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(32'h1a0ce034));
		sys_rst = 1'b1;
		srx = 1'b0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk("dll_rst", dll, 1'b1);
		rdreg(OFS_BASE);
		chk("base_rst", rd, {18'h0, BASE_RST});
		dmr_host_i.load(SEL_EXT, 14'h3);
		chk("dll_off", dll, 1'b0);
		chk("drive", drv, 1'b1);
		dmr_host_i.load(SEL_BASE, 14'h0022);
		dmr_host_i.load(2'h2, 14'h3fff);
		rdreg(OFS_EXT);
		chk("ext_hold", rd, 32'h3);
		rdreg(OFS_BASE);
		chk("base_hold", rd, 32'h22);
		srx <= 1'b1;
		@(posedge clk);
		srx <= 1'b0;
		@(posedge clk);
		chk("dll_srx", dll, 1'b1);
		dmr_host_i.load(SEL_EXT, 14'h0);
		dmr_host_i.load(SEL_BASE, 14'h0122);
		rdreg(OFS_BASE);
		chk("a8_clear", rd, 32'h22);
		dmr_host_i.load(SEL_BASE, 14'h0022);
		repeat (8) @(posedge clk);
		rdreg(OFS_STAT);
		chk("stat", rd, 32'h0002c000);
		rdreg(8'h40);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		for (int i = 0; i < 6; i++) burst(3'(i % 3 + 1), i >= 3, i[0] ? LAT_CODE_25 : LAT_CODE_2, 12'hfff);
		dmr_host_i.load(SEL_EXT, 14'h3);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk("dll_mid_rst", dll, 1'b1);
		chk("drv_mid_rst", drv, 1'b0);
		rdreg(OFS_BASE);
		chk("base_mid_rst", rd, {18'h0, BASE_RST});
		rdreg(OFS_EXT);
		chk("ext_mid_rst", rd, {18'h0, EXT_RST});
		for (int i = 0; i < 24; i++)
			burst(3'($urandom_range(3, 1)), 1'($urandom), $urandom_range(1, 0) ? LAT_CODE_25 : LAT_CODE_2,
				12'($urandom));
		end_of_test();
	end
endmodule : ddr_mode_register_burst_order_tb
`default_nettype wire
